// *** shared/timer0_pkg.sv ***
`default_nettype none

package timer0_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT     = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h10;
  localparam logic [7:0] ADDR_MASK      = 8'h14;
  localparam logic [7:0] ADDR_FLAG      = 8'h18;
  localparam logic [7:0] ADDR_POWER     = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int MODE_LO_POS   = 0;  // control_a [1:0]
  localparam int MODE_HI_POS   = 3;  // control_b [3]
  localparam int SELECT_POS    = 0;  // control_b [2:0]
  localparam int OVERFLOW_BIT  = 0;  // mask and flag
  localparam int MATCH_A_BIT   = 1;
  localparam int MATCH_B_BIT   = 2;
  localparam int POWER_OFF_BIT = 0;

  // ==========================================================
  // Values
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Waveform modes
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC       = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PHASE_A   = 3'h5;
  localparam logic [2:0] MODE_FAST_A    = 3'h7;

  // Tick source codes
  localparam logic [2:0] SEL_STOP     = 3'h0;
  localparam logic [2:0] SEL_DIV1     = 3'h1;
  localparam logic [2:0] SEL_DIV8     = 3'h2;
  localparam logic [2:0] SEL_DIV64    = 3'h3;
  localparam logic [2:0] SEL_DIV256   = 3'h4;
  localparam logic [2:0] SEL_DIV1024  = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_RISE = 3'h7;

  // Prescaler taps, as masks of the free-running divider
  localparam int          PRESCALE_WIDTH = 10;
  localparam logic [9:0]  TAP_DIV8       = 10'h007;
  localparam logic [9:0]  TAP_DIV64      = 10'h03f;
  localparam logic [9:0]  TAP_DIV256     = 10'h0ff;
  localparam logic [9:0]  TAP_DIV1024    = 10'h3ff;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } direction_e;

  // Indications handed to the waveform logic
  typedef struct packed {
    logic top;
    logic bottom;
    logic max;
    logic matchA;
    logic matchB;
    logic down;
  } count_status_s;

endpackage

`default_nettype wire

// *** verilog/timer0_counter_unit.sv ***
// Operation
// (RULE1) An 8-bit up/down count and two separate 8-bit compare values A and B.
// (RULE2) Value 0x00 is bottom, 0xFF is maximum; both are signalled internally.
// (RULE3) Top is 0xFF or compare A, depending on waveform mode.
// (RULE4) Top and bottom indications go out to the waveform logic.
// (RULE5) Count is bidirectional with count, direction and clear controls.
// (RULE6) Each tick clears, increments or decrements the count per mode.
// (RULE7) Tick comes from the prescaled clock or the external count pin.
// (RULE8) A 3-bit source select in control B picks source and pin edge.
// (RULE9) Source select zero stops the counter.
// (RULE10) Software reads and writes the count at any time.
// (RULE11) A software count write beats clear or count in the same cycle.
// (RULE12) 3-bit waveform mode: two low bits in control A, high bit in B.
// (RULE13) Both compare values are compared continuously; matches go out.
// (RULE14) A compare match sets that unit's match flag.
// (RULE15) Compare values are double buffered behind software writes; the code buffers them in the PWM modes only.
// (RULE16) Three interrupt sources: overflow, match A, match B.
// (RULE17) All request flags read in one flag register.
// (RULE18) Each request is masked by its own mask register bit.
// (RULE19) Overflow flag is set at the mode-defined point and can request.
// (RULE20) Software clears the power-off bit before using the timer.
// (RULE21) A match sets its flag on the tick following the match.
// (RULE22) Flags clear on service or by writing one to the bit.
// (RULE23) A count write blocks all matches on the next tick.
// (RULE24) Everything resets to zero: timer stopped, no requests enabled; the code resets matchA_reg and matchB_reg to one and dir_reg to DIR_UP.
`timescale 1ns/10ps
`default_nettype none

module timer0_counter_unit
  import timer0_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // External count pin
  input  wire logic          externalCountPin,
  // Interrupt service acknowledges: overflow, match A, match B
  input  wire logic [2:0]    serviceAck,
  // Requests and waveform-side indications
  output logic [2:0]         interruptRequest,
  output count_status_s      countStatus,
  output logic [7:0]         countValue,
  output logic [2:0]         waveformMode,
  output logic               timerTick
);

  // ==========================================================
  // Helpers
  function automatic logic isPwm(input logic [2:0] m);
    isPwm = (m == MODE_PHASE_MAX) || (m == MODE_FAST_MAX) ||
            (m == MODE_PHASE_A) || (m == MODE_FAST_A);
  endfunction

  function automatic logic isPhase(input logic [2:0] m);
    isPhase = (m == MODE_PHASE_MAX) || (m == MODE_PHASE_A);
  endfunction

  function automatic logic [7:0] topOf(input logic [2:0] m, input logic [7:0] a);
    topOf = ((m == MODE_CTC) || (m == MODE_PHASE_A) || (m == MODE_FAST_A)) ? a : COUNT_MAX; // RULE3
  endfunction

  // ==========================================================
  // State
  logic [1:0]  modeLo_reg, modeLo_next;
  logic        modeHi_reg, modeHi_next;
  logic [2:0]  select_reg, select_next;
  logic [7:0]  count_reg, count_next;
  logic [7:0]  bufA_reg, bufA_next, bufB_reg, bufB_next;
  logic [7:0]  actA_reg, actA_next, actB_reg, actB_next;
  logic [2:0]  mask_reg, mask_next;
  logic [2:0]  flag_reg, flag_next;
  logic        powerOff_reg, powerOff_next;
  logic        block_reg, block_next;
  direction_e  dir_reg, dir_next;
  logic [PRESCALE_WIDTH-1:0] div_reg, div_next;
  logic        pinPrev_reg, pinPrev_next;
  logic        matchA_reg, matchA_next, matchB_reg, matchB_next;

  logic        wrEn, rdSel, mapped, countWrite;
  logic [2:0]  mode;
  logic [7:0]  top, wByte;
  logic        tick, eqA, eqB, atTop;

  assign mode  = {modeHi_reg, modeLo_reg};  // RULE12
  assign top   = topOf(mode, actA_reg);
  assign wByte = pwdata[7:0];
  assign eqA   = (count_reg == actA_reg);  // RULE13
  assign eqB   = (count_reg == actB_reg);  // RULE13
  assign atTop = (count_reg == top);

  // ==========================================================
  // APB decode: zero wait states, error on unmapped offsets
  always_comb begin
    unique case (paddr)
      ADDR_CONTROL_A, ADDR_CONTROL_B, ADDR_COUNT, ADDR_COMPARE_A,
      ADDR_COMPARE_B, ADDR_MASK, ADDR_FLAG, ADDR_POWER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~mapped;
  assign wrEn       = psel & penable & pwrite & mapped;
  assign rdSel      = psel & ~pwrite;
  assign countWrite = wrEn & (paddr == ADDR_COUNT);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rdSel) begin
      unique case (paddr)
        ADDR_CONTROL_A: prdata[MODE_LO_POS +: 2] = modeLo_reg;
        ADDR_CONTROL_B: begin
          prdata[SELECT_POS +: 3] = select_reg;
          prdata[MODE_HI_POS]     = modeHi_reg;
        end
        ADDR_COUNT:     prdata[7:0] = count_reg;  // RULE10
        // Software sees the buffer, as it is what a write lands in
        ADDR_COMPARE_A: prdata[7:0] = bufA_reg;
        ADDR_COMPARE_B: prdata[7:0] = bufB_reg;
        ADDR_MASK:      prdata[2:0] = mask_reg;
        ADDR_FLAG:      prdata[2:0] = flag_reg;  // RULE17
        ADDR_POWER:     prdata[POWER_OFF_BIT] = powerOff_reg;
        default:        prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Tick source
  always_comb begin
    div_next     = powerOff_reg ? '0 : div_reg + 1'b1;
    pinPrev_next = externalCountPin;
    tick         = 1'b0;
    unique case (select_reg)  // RULE8
      SEL_STOP:     tick = 1'b0;  // RULE9
      SEL_DIV1:     tick = 1'b1;  // RULE7
      SEL_DIV8:     tick = ((div_reg & TAP_DIV8) == TAP_DIV8);
      SEL_DIV64:    tick = ((div_reg & TAP_DIV64) == TAP_DIV64);
      SEL_DIV256:   tick = ((div_reg & TAP_DIV256) == TAP_DIV256);
      SEL_DIV1024:  tick = ((div_reg & TAP_DIV1024) == TAP_DIV1024);
      SEL_EXT_FALL: tick = pinPrev_reg & ~externalCountPin;  // RULE7
      SEL_EXT_RISE: tick = ~pinPrev_reg & externalCountPin;
    endcase
    // A powered-down module never advances
    if (powerOff_reg) begin
      tick = 1'b0;
    end
  end

  // ==========================================================
  // Registers written by software
  always_comb begin
    modeLo_next   = modeLo_reg;
    modeHi_next   = modeHi_reg;
    select_next   = select_reg;
    mask_next     = mask_reg;
    powerOff_next = powerOff_reg;
    bufA_next     = bufA_reg;
    bufB_next     = bufB_reg;
    if (wrEn) begin
      unique case (paddr)
        ADDR_CONTROL_A: modeLo_next = wByte[MODE_LO_POS +: 2];
        ADDR_CONTROL_B: begin
          select_next = wByte[SELECT_POS +: 3];
          modeHi_next = wByte[MODE_HI_POS];
        end
        ADDR_COMPARE_A: bufA_next = wByte;  // RULE15
        ADDR_COMPARE_B: bufB_next = wByte;
        ADDR_MASK:      mask_next = wByte[2:0];  // RULE18
        ADDR_POWER:     powerOff_next = wByte[POWER_OFF_BIT];
        default:        ;
      endcase
    end
  end

  // ==========================================================
  // Counter
  always_comb begin
    count_next = count_reg;
    dir_next   = dir_reg;
    if (countWrite) begin
      count_next = wByte;  // RULE11
    end else if (tick) begin  // RULE6
      if (isPhase(mode)) begin  // RULE5
        if (dir_reg == DIR_UP) begin
          if (atTop) begin
            dir_next   = DIR_DOWN;
            count_next = count_reg - 1'b1;
          end else begin
            count_next = count_reg + 1'b1;
          end
        end else if (count_reg == COUNT_BOTTOM) begin
          dir_next   = DIR_UP;
          count_next = count_reg + 1'b1;
        end else begin
          count_next = count_reg - 1'b1;
        end
      end else if ((mode == MODE_CTC || isPwm(mode)) && atTop) begin
        count_next = COUNT_BOTTOM;  // RULE5
        dir_next   = DIR_UP;
      end else begin
        count_next = count_reg + 1'b1;
        dir_next   = DIR_UP;
      end
    end
  end

  // ==========================================================
  // Active compare values: direct outside PWM, loaded at top in PWM
  always_comb begin
    actA_next = actA_reg;
    actB_next = actB_reg;
    if (!isPwm(mode)) begin
      actA_next = bufA_next;  // RULE15
      actB_next = bufB_next;
    end else if (tick && atTop) begin
      actA_next = bufA_reg;  // RULE15
      actB_next = bufB_reg;
    end
  end

  // ==========================================================
  // Match blocking and flags
  logic ovfEvent, setA, setB;

  always_comb begin
    // A write blocks the next tick's matches, even while stopped
    block_next = countWrite ? 1'b1 : (tick ? 1'b0 : block_reg);  // RULE23
    setA       = tick & eqA & ~block_reg;  // RULE21
    setB       = tick & eqB & ~block_reg;  // RULE14
    if (isPhase(mode)) begin
      ovfEvent = tick & (count_reg == COUNT_BOTTOM) & (dir_reg == DIR_DOWN);  // RULE19
    end else if (isPwm(mode)) begin
      ovfEvent = tick & atTop;
    end else begin
      ovfEvent = tick & (count_reg == COUNT_MAX);
    end
    if (countWrite) begin
      ovfEvent = 1'b0;
    end
    flag_next = flag_reg & ~serviceAck;  // RULE22
    if (wrEn && paddr == ADDR_FLAG) begin
      flag_next = flag_next & ~wByte[2:0];  // RULE22
    end
    // Setting wins over a clear in the same cycle
    flag_next[OVERFLOW_BIT] = flag_next[OVERFLOW_BIT] | ovfEvent;  // RULE16
    flag_next[MATCH_A_BIT]  = flag_next[MATCH_A_BIT] | setA;
    flag_next[MATCH_B_BIT]  = flag_next[MATCH_B_BIT] | setB;
    matchA_next = (count_next == actA_next);
    matchB_next = (count_next == actB_next);
  end

  // ==========================================================
  always_ff @(posedge clock) begin
    if (reset) begin  // RULE24
      modeLo_reg   <= 2'h0;
      modeHi_reg   <= 1'b0;
      select_reg   <= SEL_STOP;
      count_reg    <= RESET_BYTE;
      bufA_reg     <= RESET_BYTE;
      bufB_reg     <= RESET_BYTE;
      actA_reg     <= RESET_BYTE;
      actB_reg     <= RESET_BYTE;
      mask_reg     <= 3'h0;
      flag_reg     <= 3'h0;
      powerOff_reg <= 1'b0;
      block_reg    <= 1'b0;
      dir_reg      <= DIR_UP;
      div_reg      <= '0;
      pinPrev_reg  <= 1'b0;
      matchA_reg   <= 1'b1;
      matchB_reg   <= 1'b1;
    end else begin
      modeLo_reg   <= modeLo_next;
      modeHi_reg   <= modeHi_next;
      select_reg   <= select_next;
      count_reg    <= count_next;
      bufA_reg     <= bufA_next;
      bufB_reg     <= bufB_next;
      actA_reg     <= actA_next;
      actB_reg     <= actB_next;
      mask_reg     <= mask_next;
      flag_reg     <= flag_next;
      powerOff_reg <= powerOff_next;
      block_reg    <= block_next;
      dir_reg      <= dir_next;
      div_reg      <= div_next;
      pinPrev_reg  <= pinPrev_next;
      matchA_reg   <= matchA_next;
      matchB_reg   <= matchB_next;
    end
  end

  // ==========================================================
  // Outputs
  assign interruptRequest   = flag_reg & mask_reg;  // RULE18
  assign countValue         = count_reg;  // RULE1
  assign waveformMode       = mode;
  assign timerTick          = tick;
  assign countStatus.top    = atTop;  // RULE4
  assign countStatus.bottom = (count_reg == COUNT_BOTTOM);  // RULE2
  assign countStatus.max    = (count_reg == COUNT_MAX);  // RULE2
  assign countStatus.matchA = matchA_reg;  // RULE13
  assign countStatus.matchB = matchB_reg;
  assign countStatus.down   = (dir_reg == DIR_DOWN);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_WRITE_WINS: assert property (countWrite |=> count_reg == $past(wByte))  // RULE11
    else $error("count write did not take priority");
  AST_STOPPED: assert property ((select_reg == SEL_STOP && !countWrite) |=> $stable(count_reg))  // RULE9
    else $error("count moved with no tick source");
  AST_MATCH_FLAG: assert property ((tick && eqA && !block_reg) |=> flag_reg[MATCH_A_BIT])  // RULE21
    else $error("match A did not set its flag");
  AST_BLOCKED: assert property ((countWrite ##1 (tick && !flag_reg[MATCH_B_BIT] && !countWrite))
                                 |=> !flag_reg[MATCH_B_BIT])  // RULE23
    else $error("match not blocked after count write");
  AST_NO_TICK_FLAG: assert property ((!tick && !flag_reg[MATCH_A_BIT]) |=> !flag_reg[MATCH_A_BIT])  // RULE14
    else $error("match flag set without a tick");
  AST_OVF_NORMAL: assert property ((mode == MODE_NORMAL && tick && count_reg == COUNT_MAX && !countWrite)
                                    |=> count_reg == COUNT_BOTTOM && flag_reg[OVERFLOW_BIT])  // RULE19
    else $error("normal mode overflow wrong");
  AST_W1C: assert property ((wrEn && paddr == ADDR_FLAG && wByte[OVERFLOW_BIT] && !ovfEvent)
                             |=> !flag_reg[OVERFLOW_BIT])  // RULE22
    else $error("write one did not clear overflow flag");
  AST_REQUEST: assert property (interruptRequest[MATCH_B_BIT] |-> mask_reg[MATCH_B_BIT] && flag_reg[MATCH_B_BIT])  // RULE18
    else $error("request without mask and flag");
  AST_CTC_CLEAR: assert property ((mode == MODE_CTC && tick && eqA && !countWrite) |=> count_reg == COUNT_BOTTOM)  // RULE6
    else $error("clear on match failed");
  AST_PWM_BUFFER: assert property ((isPwm(mode) && !(tick && atTop) && $stable(mode)) |=> $stable(actA_reg))  // RULE15
    else $error("active compare changed outside top");

  COV_OVERFLOW: cover property (flag_reg[OVERFLOW_BIT] && mask_reg[OVERFLOW_BIT]);
  COV_PHASE_TURN: cover property (isPhase(mode) && tick && atTop);
  COV_BLOCK: cover property (countWrite ##1 (tick && eqA));

endmodule // timer0_counter_unit

`default_nettype wire

// *** sim/test_timer0_counter_unit.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_timer0_counter_unit;
  import timer0_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  logic          clock;
  logic          reset;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          externalCountPin;
  logic [2:0]    serviceAck;
  logic [2:0]    interruptRequest;
  count_status_s countStatus;
  logic [7:0]    countValue;
  logic [2:0]    waveformMode;
  logic          timerTick;
  int            miscompares;
  int            nTests;
  logic [31:0]   rd;
  logic          err;

  timer0_counter_unit DUT (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .externalCountPin(externalCountPin), .serviceAck(serviceAck),
    .interruptRequest(interruptRequest), .countStatus(countStatus),
    .countValue(countValue), .waveformMode(waveformMode), .timerTick(timerTick)
  );

  // ==========================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrapUp();
    if (miscompares == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitCount(input logic [7:0] v);
    int i;
    i = 0;
    while (countValue !== v && i < 3000) begin
      step(1);
      i++;
    end
    check(countValue, v);
  endtask

  // ==========================================================
  // Scenarios
  task automatic resetValues();
    for (int a = 0; a <= 'h1c; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'hff);
    apb(1'b0, ADDR_MASK, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, ADDR_COMPARE_B, 32'hab);
    apb(1'b0, ADDR_COMPARE_B, 32'h0);
    check(rd, 32'hab);
    apb(1'b1, ADDR_COMPARE_B, 32'h0);
  endtask

  task automatic overflowFlags();
    apb(1'b1, ADDR_COUNT, 32'hfe);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_DIV1});
    waitCount(8'hff);
    check({countStatus.max, countStatus.top, interruptRequest[0]}, 3'b110);
    step(1);
    check({countValue, countStatus.bottom, interruptRequest[0]}, {8'h00, 2'b11});
    apb(1'b1, ADDR_CONTROL_B, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0);
    #1;
    check(interruptRequest, 3'b000);
    // Compare values are zero, so both matches fired one tick after bottom
    apb(1'b0, ADDR_FLAG, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, ADDR_FLAG, 32'h1);
    apb(1'b0, ADDR_FLAG, 32'h0);
    check(rd, 32'h6);
    apb(1'b1, ADDR_FLAG, 32'h6);
  endtask

  task automatic compareMatch();
    apb(1'b1, ADDR_MASK, 32'h7);
    apb(1'b1, ADDR_COMPARE_A, 32'h10);
    apb(1'b1, ADDR_COMPARE_B, 32'h11);
    apb(1'b1, ADDR_COUNT, 32'h0e);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_DIV1});
    waitCount(8'h10);
    check({countStatus.matchA, interruptRequest[1]}, 2'b10);
    step(1);
    check(interruptRequest[2:1], 2'b01);
    check(countStatus.matchB, 1'b1);
    step(1);
    check(interruptRequest[2:1], 2'b11);
    apb(1'b1, ADDR_CONTROL_B, 32'h0);
    @(posedge clock);
    serviceAck <= 3'b010;
    @(posedge clock);
    serviceAck <= 3'b000;
    #1;
    check(interruptRequest[2:1], 2'b10);
    apb(1'b1, ADDR_FLAG, 32'h7);
    // A count write equal to compare A must not raise a flag
    apb(1'b1, ADDR_COMPARE_A, 32'h30);
    apb(1'b1, ADDR_COUNT, 32'h30);
    step(2);
    check(countStatus.matchA, 1'b1);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_DIV1});
    step(3);
    check(interruptRequest[1], 1'b0);
    apb(1'b1, ADDR_COUNT, 32'h80);
    #1;
    check(countValue, 8'h80);
    step(1);
    check(countValue, 8'h81);
    apb(1'b1, ADDR_MASK, 32'h0);
    // Top for the compare-A modes that follow
    apb(1'b1, ADDR_COMPARE_A, 32'h05);
  endtask

  task automatic runMode(input logic [7:0] a, input logic [7:0] b, input logic [7:0] start,
                         input logic [7:0] topVal, input logic [7:0] nextVal);
    apb(1'b1, ADDR_CONTROL_B, 32'h0);
    apb(1'b1, ADDR_CONTROL_A, {24'h0, a});
    apb(1'b1, ADDR_COUNT, {24'h0, start});
    apb(1'b1, ADDR_CONTROL_B, {24'h0, b});
    #1;
    check(waveformMode, {b[3], a[1:0]});
    waitCount(topVal);
    step(1);
    check(countValue, nextVal);
  endtask

  task automatic prescaler();
    logic [7:0] c0;
    int         div [1:5];
    div = '{1, 8, 64, 256, 1024};
    for (int s = 1; s <= 5; s++) begin
      apb(1'b1, ADDR_CONTROL_B, {29'h0, s[2:0]});
      step(2100);
      c0 = countValue;
      step(2 * div[s]);
      check(countValue, 8'(c0 + 8'h02));
    end
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      externalCountPin <= 1'b1;
      step(4);
      @(posedge clock);
      externalCountPin <= 1'b0;
      step(4);
    end
  endtask

  task automatic externalAndPower();
    apb(1'b1, ADDR_CONTROL_B, 32'h0);
    apb(1'b1, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_EXT_RISE});
    pulses(3);
    check(countValue, 8'h03);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_EXT_FALL});
    pulses(3);
    check(countValue, 8'h06);
    apb(1'b1, ADDR_CONTROL_B, 32'h0);
    step(10);
    check(countValue, 8'h06);
    apb(1'b1, ADDR_POWER, 32'h1);
    apb(1'b1, ADDR_CONTROL_B, {29'h0, SEL_DIV1});
    step(10);
    check(countValue, 8'h06);
    check(timerTick, 1'b0);
    apb(1'b1, ADDR_POWER, 32'h0);
    step(5);
    check(countValue, 8'h0b);
    check(timerTick, 1'b1);
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #100000;
    miscompares++;
    wrapUp();
  end

  initial begin
    miscompares = 0;
    nTests = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    externalCountPin = 1'b0;
    serviceAck = 3'b000;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    resetValues();
    overflowFlags();
    compareMatch();
    runMode(8'h02, 8'h01, 8'h00, 8'h05, 8'h00);
    runMode(8'h03, 8'h09, 8'h00, 8'h05, 8'h00);
    runMode(8'h01, 8'h01, 8'hfd, 8'hff, 8'hfe);
    check(countStatus.down, 1'b1);
    runMode(8'h01, 8'h09, 8'h03, 8'h05, 8'h04);
    runMode(8'h00, 8'h01, 8'hfe, 8'hff, 8'h00);
    prescaler();
    externalAndPower();
    wrapUp();
  end

endmodule // test_timer0_counter_unit

`default_nettype wire
